// ### logic/gpe_cfg.svh
// Constants for the two-port pin block with edge events and wake request
// What this block does
// RULE_01: Reading the port A level register returns the live level of all eight pins.
// RULE_02: Reading the port B level register returns five live pin levels with bits 7-5 as zero.
// RULE_03: Each low port A drive-type bit picks open drain at 0 and push pull at 1, resetting to 0.
// RULE_04: A wake request is raised while any low port A event flag and its enable are both set.
// RULE_05: Each low port A edge-select bit picks rising edge at 0 and falling edge at 1, default 0.
// RULE_06: A selected edge on a low port A pin in input mode sets and holds its event flag.
// RULE_07: Writing 1 to an event flag clears it to 0.
// RULE_08: Each port B direction bit makes its pin an input at 0 and an output at 1, reset 0.
// RULE_09: Each port B output value bit is the level driven in output mode, reset 1.
// RULE_10: Each port A direction bit makes its pin an input at 0 and an output at 1, reset 0.
// RULE_11: Each port A output value bit is the level driven in output mode, reset 1.
// RULE_12: Reserved bits read 0 and ignore writes, and writing 0 to an event flag keeps it.
`ifndef GPE_CFG_SVH
`define GPE_CFG_SVH

// ==========================================================
// Register indices, byte address is four times the index
`define GPE_IDX_PB_DIRECTION   8'h0A0
`define GPE_IDX_PB_OUT_VALUE   8'h0A1
`define GPE_IDX_PB_PIN_LEVEL   8'h0A2
`define GPE_IDX_PA_DIRECTION   8'h0B0
`define GPE_IDX_PA_OUT_VALUE   8'h0B1
`define GPE_IDX_PA_PIN_LEVEL   8'h0B2
`define GPE_IDX_PA_DRIVE_TYPE  8'h0B3
`define GPE_IDX_PA_WAKE_EN     8'h0B4
`define GPE_IDX_PA_EDGE_SEL    8'h0B5
`define GPE_IDX_PA_EVENT_FLAGS 8'h0B6

// ==========================================================
// Widths and reset values
`define GPE_PA_W         8
`define GPE_PB_W         5
`define GPE_EDGE_W       4
`define GPE_RST_DIR      8'h00
`define GPE_RST_VAL      8'hFF
`define GPE_RST_DRIVE    8'h00
`define GPE_RST_WAKE     8'h00
`define GPE_RST_EDGE     8'h00
`define GPE_RST_FLAGS    8'h00

`endif

// ### logic/gpe_pkg.sv
// Types shared by the pin block
package gpe_pkg;
	// ==========================================================
	// Pin drive bundles, output enable active low
	typedef struct packed {
		logic [7:0] level;
		logic [7:0] oe_n;
	} gpe_pa_drv_t;

	typedef struct packed {
		logic [4:0] level;
		logic [4:0] oe_n;
	} gpe_pb_drv_t;
endpackage : gpe_pkg

// ### logic/gpe_edge_det.sv
// Per-pin edge detector for the event pins
`timescale 1ns/10ps
module gpe_edge_det #(
	parameter int W = 4
) (
	// Clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	// Pin side
	input  wire logic [W-1:0] pin_i,
	input  wire logic [W-1:0] in_mode_i,
	input  wire logic [W-1:0] falling_i,
	// Event pulses
	output logic      [W-1:0] event_o
);
	logic [W-1:0] prev_reg;
	logic         primed_reg;

	if (W < 1 || W > 8) begin : g_bad_w
		$error("gpe_edge_det: W out of range");
	end

	// No edge on the first cycle after reset, the old level is unknown
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			primed_reg <= 1'b0;
		end else begin
			primed_reg <= 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		prev_reg <= pin_i;
	end

	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			assign event_o[g] = primed_reg && in_mode_i[g] &&
				(falling_i[g] ? (prev_reg[g] && !pin_i[g])     // RULE_05
				              : (!prev_reg[g] && pin_i[g]));   // RULE_05
		end
	endgenerate
endmodule : gpe_edge_det

// ### logic/gpe_top.sv
// Two-port pin block with edge events, wake request and Wishbone registers
//
// Our own choice: the Wishbone register port.
`timescale 1ns/10ps
`include "gpe_cfg.svh"
module gpe_top #(
	parameter int EDGE_PINS = `GPE_EDGE_W
) (
	// Clock and reset
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	// Wishbone slave
	input  wire logic                cyc_i,
	input  wire logic                stb_i,
	input  wire logic                we_i,
	input  wire logic [9:0]          adr_i,
	input  wire logic [3:0]          sel_i,
	input  wire logic [31:0]         dat_i,
	output logic      [31:0]         dat_o,
	output logic                     ack_o,
	// Port A pins
	input  wire logic [7:0]          pa_in_i,
	output gpe_pkg::gpe_pa_drv_t     pa_drv_o,
	// Port B pins
	input  wire logic [4:0]          pb_in_i,
	output gpe_pkg::gpe_pb_drv_t     pb_drv_o,
	// Wake request
	output logic                     wake_o
);
	import gpe_pkg::*;

	if (EDGE_PINS < 1 || EDGE_PINS > `GPE_PA_W) begin : g_bad_cfg
		$error("gpe_top: EDGE_PINS out of range");
	end

	// ==========================================================
	// Registers
	logic [7:0]           pa_dir_reg;
	logic [7:0]           pa_val_reg;
	logic [EDGE_PINS-1:0] pa_pp_reg;
	logic [EDGE_PINS-1:0] pa_wake_en_reg;
	logic [EDGE_PINS-1:0] pa_edge_sel_reg;
	logic [EDGE_PINS-1:0] pa_flags_reg;
	logic [EDGE_PINS-1:0] pa_flags_next;
	logic [4:0]           pb_dir_reg;
	logic [4:0]           pb_val_reg;
	logic                 ack_reg;
	logic [31:0]          dat_reg;
	logic                 wake_reg;
	gpe_pa_drv_t          pa_drv_reg;
	gpe_pb_drv_t          pb_drv_reg;
	logic [EDGE_PINS-1:0] edge_evt;
	logic [7:0]           idx;
	logic                 wr_go;
	logic [7:0]           wr_byte;
	logic [7:0]           rd_next;

	assign idx     = adr_i[9:2];
	// Write commits at the edge where the master sees ack
	assign wr_go   = cyc_i && stb_i && we_i && ack_reg && sel_i[0];
	assign wr_byte = dat_i[7:0];

	assign dat_o    = dat_reg;
	assign ack_o    = ack_reg;
	assign pa_drv_o = pa_drv_reg;
	assign pb_drv_o = pb_drv_reg;
	assign wake_o   = wake_reg;

	// ==========================================================
	// Bus handshake, one wait state then ack for one cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= cyc_i && stb_i && !ack_reg;
		end
	end

	// ==========================================================
	// Read mux, unmapped indices read zero
	always_comb begin
		rd_next = 8'h00;
		unique case (idx)
			`GPE_IDX_PB_DIRECTION:   rd_next = {3'h0, pb_dir_reg};              // RULE_12
			`GPE_IDX_PB_OUT_VALUE:   rd_next = {3'h0, pb_val_reg};              // RULE_12
			`GPE_IDX_PB_PIN_LEVEL:   rd_next = {3'h0, pb_in_i};                 // RULE_02
			`GPE_IDX_PA_DIRECTION:   rd_next = pa_dir_reg;
			`GPE_IDX_PA_OUT_VALUE:   rd_next = pa_val_reg;
			`GPE_IDX_PA_PIN_LEVEL:   rd_next = pa_in_i;                         // RULE_01
			`GPE_IDX_PA_DRIVE_TYPE:  rd_next = 8'(pa_pp_reg);                   // RULE_12
			`GPE_IDX_PA_WAKE_EN:     rd_next = 8'(pa_wake_en_reg);              // RULE_12
			`GPE_IDX_PA_EDGE_SEL:    rd_next = 8'(pa_edge_sel_reg);             // RULE_12
			`GPE_IDX_PA_EVENT_FLAGS: rd_next = 8'(pa_flags_reg);                // RULE_12
			default:                 rd_next = 8'h00;
		endcase
	end

	// Data captured as ack rises, stands through the ack cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_reg <= 32'h0000_0000;
		end else if (cyc_i && stb_i && !we_i && !ack_reg) begin
			dat_reg <= {24'h00_0000, rd_next};
		end
	end

	// ==========================================================
	// Port A control registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pa_dir_reg <= `GPE_RST_DIR;                                     // RULE_10
			pa_val_reg <= `GPE_RST_VAL;                                     // RULE_11
		end else if (wr_go) begin
			if (idx == `GPE_IDX_PA_DIRECTION) pa_dir_reg <= wr_byte;        // RULE_10
			if (idx == `GPE_IDX_PA_OUT_VALUE) pa_val_reg <= wr_byte;        // RULE_11
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pa_pp_reg       <= EDGE_PINS'(`GPE_RST_DRIVE);                  // RULE_03
			pa_wake_en_reg  <= EDGE_PINS'(`GPE_RST_WAKE);
			pa_edge_sel_reg <= EDGE_PINS'(`GPE_RST_EDGE);                   // RULE_05
		end else if (wr_go) begin
			if (idx == `GPE_IDX_PA_DRIVE_TYPE)
				pa_pp_reg <= wr_byte[EDGE_PINS-1:0];                        // RULE_03
			if (idx == `GPE_IDX_PA_WAKE_EN)
				pa_wake_en_reg <= wr_byte[EDGE_PINS-1:0];                   // RULE_12
			if (idx == `GPE_IDX_PA_EDGE_SEL)
				pa_edge_sel_reg <= wr_byte[EDGE_PINS-1:0];                  // RULE_05
		end
	end

	// ==========================================================
	// Port B control registers, upper bits dropped on write
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pb_dir_reg <= 5'(`GPE_RST_DIR);                                 // RULE_08
			pb_val_reg <= 5'(`GPE_RST_VAL);                                 // RULE_09
		end else if (wr_go) begin
			if (idx == `GPE_IDX_PB_DIRECTION) pb_dir_reg <= wr_byte[4:0];   // RULE_08
			if (idx == `GPE_IDX_PB_OUT_VALUE) pb_val_reg <= wr_byte[4:0];   // RULE_09
		end
	end

	// ==========================================================
	// Edge events and sticky flags
	gpe_edge_det #(
		.W         (EDGE_PINS)
	) u_edge (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.pin_i     (pa_in_i[EDGE_PINS-1:0]),
		.in_mode_i (~pa_dir_reg[EDGE_PINS-1:0]),                            // RULE_10
		.falling_i (pa_edge_sel_reg),
		.event_o   (edge_evt)
	);

	// Set beats clear so an edge in the clearing cycle is kept
	always_comb begin
		pa_flags_next = pa_flags_reg;
		if (wr_go && idx == `GPE_IDX_PA_EVENT_FLAGS)
			pa_flags_next = pa_flags_next & ~wr_byte[EDGE_PINS-1:0];       // RULE_07
		pa_flags_next = pa_flags_next | edge_evt;                           // RULE_06
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pa_flags_reg <= EDGE_PINS'(`GPE_RST_FLAGS);
		end else begin
			pa_flags_reg <= pa_flags_next;                                  // RULE_06
		end
	end

	// Registered so a flag clear never glitches the wake line
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wake_reg <= 1'b0;
		end else begin
			wake_reg <= |(pa_flags_reg & pa_wake_en_reg);                   // RULE_04
		end
	end

	// ==========================================================
	// Pin drivers, low bits may be open drain, the rest push pull
	// One register for the bundle keeps each bit on a single driver
	logic [7:0] pa_oe_n_next;
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_pa
			if (g < EDGE_PINS) begin : g_od
				assign pa_oe_n_next[g] = !(pa_dir_reg[g] &&
					(pa_pp_reg[g] || !pa_val_reg[g]));                   // RULE_03
			end else begin : g_pp
				assign pa_oe_n_next[g] = !pa_dir_reg[g];                 // RULE_10
			end
		end
	endgenerate

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pa_drv_reg.level <= `GPE_RST_VAL;
			pa_drv_reg.oe_n  <= 8'hFF;
		end else begin
			pa_drv_reg.level <= pa_val_reg;                                 // RULE_11
			pa_drv_reg.oe_n  <= pa_oe_n_next;                               // RULE_03
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pb_drv_reg.level <= 5'(`GPE_RST_VAL);
			pb_drv_reg.oe_n  <= 5'h1F;
		end else begin
			pb_drv_reg.level <= pb_val_reg;                                 // RULE_09
			pb_drv_reg.oe_n  <= ~pb_dir_reg;                                // RULE_08
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	logic rd_pa;
	logic rd_pb;
	logic rd_dt;
	assign rd_pa = ack_reg && !we_i && idx == `GPE_IDX_PA_PIN_LEVEL;
	assign rd_pb = ack_reg && !we_i && idx == `GPE_IDX_PB_PIN_LEVEL;
	assign rd_dt = ack_reg && !we_i && idx == `GPE_IDX_PA_DRIVE_TYPE;

	a_pa_level_read: assert property (rd_pa |-> dat_o[7:0] == $past(pa_in_i)) // RULE_01
		else $error("port A level read mismatch");
	a_pb_level_read: assert property (                                      // RULE_02
		rd_pb |-> dat_o[7:5] == 3'h0 && dat_o[4:0] == $past(pb_in_i))
		else $error("port B level read mismatch");
	a_open_drain_off: assert property (                                     // RULE_03
		pa_dir_reg[0] && !pa_pp_reg[0] && pa_val_reg[0] |=> pa_drv_o.oe_n[0])
		else $error("open drain drove a high level");
	a_wake_follows: assert property (                                       // RULE_04
		(pa_flags_reg[0] && pa_wake_en_reg[0]) |=> wake_o)
		else $error("wake request missing");
	a_edge_sets_flag: assert property (                                     // RULE_06
		$rose(pa_in_i[0]) && !pa_edge_sel_reg[0] && !pa_dir_reg[0]
		&& !$past(rst_i) |=> pa_flags_reg[0])
		else $error("rising edge did not set flag");
	a_flag_clears: assert property (                                        // RULE_07
		wr_go && idx == `GPE_IDX_PA_EVENT_FLAGS && dat_i[0] && !edge_evt[0]
		|=> !pa_flags_reg[0])
		else $error("write one did not clear flag");
	a_pb_output_drive: assert property (                                    // RULE_08
		pb_dir_reg[0] |=> !pb_drv_o.oe_n[0] && pb_drv_o.level[0] == $past(pb_val_reg[0]))
		else $error("port B output not driven");
	a_pa_input_float: assert property (!pa_dir_reg[5] |=> pa_drv_o.oe_n[5]) // RULE_10
		else $error("port A input pin driven");
	a_pa_push_value: assert property (                                      // RULE_11
		pa_dir_reg[6] |=> !pa_drv_o.oe_n[6] && pa_drv_o.level[6] == $past(pa_val_reg[6]))
		else $error("port A output value wrong");
	a_reserved_zero: assert property (rd_dt |-> dat_o[31:4] == 28'h000_0000) // RULE_12
		else $error("reserved bits not zero");
	a_flag_holds: assert property (                                         // RULE_12
		pa_flags_reg[0] && !(wr_go && idx == `GPE_IDX_PA_EVENT_FLAGS && dat_i[0])
		|=> pa_flags_reg[0])
		else $error("event flag lost");
	a_ack_single: assert property (ack_o |=> !ack_o)
		else $error("ack held two cycles");

	// ==========================================================
	// Pin drive, event and bus checks
	a_od_pull_low: assert property (                                        // RULE_03
		pa_dir_reg[1] && !pa_val_reg[1] |=> !pa_drv_o.oe_n[1] && !pa_drv_o.level[1])
		else $error("open drain did not pull low");
	a_fall_sets_flag: assert property (                                     // RULE_05
		$fell(pa_in_i[1]) && pa_edge_sel_reg[1] && !pa_dir_reg[1]
		&& !$past(rst_i) |=> pa_flags_reg[1])
		else $error("falling edge did not set flag");
	// A fall under rising select must leave a clear flag clear
	a_wrong_edge_quiet: assert property (                                   // RULE_05
		$fell(pa_in_i[0]) && !pa_edge_sel_reg[0] && !pa_flags_reg[0] |=> !pa_flags_reg[0])
		else $error("unselected edge set flag");
	a_output_no_event: assert property (pa_dir_reg[2] |-> !edge_evt[2])  // RULE_10
		else $error("edge seen on output pin");
	a_pa_od_input: assert property (!pa_dir_reg[2] |=> pa_drv_o.oe_n[2]) // RULE_10
		else $error("low port A input pin driven");
	a_wake_off: assert property (                                           // RULE_04
		!(|(pa_flags_reg & pa_wake_en_reg)) |=> !wake_o)
		else $error("wake request without enabled flag");
	a_pb_input_float: assert property (!pb_dir_reg[4] |=> pb_drv_o.oe_n[4]) // RULE_08
		else $error("port B input pin driven");
	a_pb_value_drive: assert property (                                     // RULE_09
		pb_dir_reg[3] |=> pb_drv_o.level[3] == $past(pb_val_reg[3]))
		else $error("port B output value wrong");
	a_read_upper_zero: assert property (                                    // RULE_12
		ack_o && !we_i |-> dat_o[31:8] == 24'h00_0000)
		else $error("read data upper bits not zero");
	// Byte lane 0 off: the write must be dropped
	a_sel_ignored: assert property (
		cyc_i && stb_i && we_i && ack_reg && !sel_i[0]
		|=> $stable(pb_val_reg) && $stable(pa_val_reg))
		else $error("write with lane 0 off took effect");

	c_edge_event: cover property (edge_evt[0] ##1 pa_flags_reg[0]);
	c_wake_raise: cover property (!wake_o ##1 wake_o);
	c_flag_clear: cover property (pa_flags_reg[0] ##1 !pa_flags_reg[0]);
	c_level_read: cover property (rd_pa);
	c_pb_drive: cover property (pb_dir_reg[0] ##1 !pb_drv_o.oe_n[0]);
endmodule : gpe_top

// ### test/gpe_board_model.sv
// Board side of the shared pins: resolves each wire from both drivers
`timescale 1ns/10ps
module gpe_board_model (
	// Block drive
	input  wire gpe_pkg::gpe_pa_drv_t pa_drv_i,
	input  wire gpe_pkg::gpe_pb_drv_t pb_drv_i,
	// Board drive, used only where the block lets go
	input  wire logic [7:0]           pa_ext_i,
	input  wire logic [4:0]           pb_ext_i,
	// Resolved wire levels
	output logic      [7:0]           pa_pin_o,
	output logic      [4:0]           pb_pin_o
);
	import gpe_pkg::*;
	// ==========================================================
	// Wire resolution
	// Driven bits show the block's level, released bits the board's
	assign pa_pin_o = (pa_drv_i.oe_n & pa_ext_i) | (~pa_drv_i.oe_n & pa_drv_i.level);
	assign pb_pin_o = (pb_drv_i.oe_n & pb_ext_i) | (~pb_drv_i.oe_n & pb_drv_i.level);
endmodule : gpe_board_model

// ### test/gpe_top_tb.sv
// Self-checking testbench for the two-port pin block
`timescale 1ns/10ps
module gpe_top_tb;
	import gpe_pkg::*;
	// ==========================================================
	// Signals
	logic        clk_i, rst_i, cyc, stb, we, ack, wake;
	logic [9:0]  adr;
	logic [31:0] wdat, rdat, q;
	logic [3:0]  sel;
	logic [7:0]  pa_ext, pa_pin;
	logic [4:0]  pb_ext, pb_pin;
	gpe_pa_drv_t pa_drv;
	gpe_pb_drv_t pb_drv;
	int          fails, n_checks, cyc_cnt;
	logic [7:0]  ix [8] = '{8'hA0, 8'hA1, 8'hB0, 8'hB1, 8'hB3, 8'hB4, 8'hB5, 8'h10};
	logic [7:0]  rv [8] = '{8'h00, 8'h1F, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
	logic [7:0]  fv [8] = '{8'h1F, 8'h1F, 8'hFF, 8'hFF, 8'h0F, 8'h0F, 8'h0F, 8'h00};

	// ==========================================================
	// Design and board
	gpe_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
		.adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
		.pa_in_i(pa_pin), .pa_drv_o(pa_drv), .pb_in_i(pb_pin), .pb_drv_o(pb_drv),
		.wake_o(wake));
	gpe_board_model u_board (.pa_drv_i(pa_drv), .pb_drv_i(pb_drv), .pa_ext_i(pa_ext),
		.pb_ext_i(pb_ext), .pa_pin_o(pa_pin), .pb_pin_o(pb_pin));

	// ==========================================================
	// Tasks
	task automatic report_and_stop;
		if (fails == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			fails++;
			$display("ERROR %0t: got %h want %h", $time, g, e);
		end
	endtask : chk

	// Classic cycle; waits for ack with no assumed latency
	task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d);
		@(posedge clk_i);
		{cyc, stb, we} <= {2'b11, w};
		adr <= {i, 2'b00};
		wdat <= {24'h00_0000, d};
		do @(posedge clk_i); while (ack !== 1'b1);
		q = rdat;
		{cyc, stb} <= 2'b00;
	endtask : bus

	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		bus(1'b1, i, d);
	endtask : wr

	task automatic rc(input logic [7:0] i, input logic [7:0] e);
		bus(1'b0, i, 8'h00);
		chk(q, {24'h00_0000, e});
	endtask : rc

	// Margin for outputs that follow one edge after a register
	task automatic settle;
		repeat (3) @(posedge clk_i);
	endtask : settle

	// ==========================================================
	// Clock and timeout
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	always @(posedge clk_i) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 5000) begin
			fails++;
			report_and_stop;
		end
	end

	// ==========================================================
	// Tests
	initial begin
		{rst_i, cyc, stb, we, adr, wdat, q} = {1'b1, 3'b000, 10'h000, 64'h0};
		{pa_ext, pb_ext, sel, fails, n_checks} = {8'h0F, 5'h15, 4'h1, 64'h0};
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		chk({16'h0000, pa_drv}, 32'h0000_FFFF);
		chk({22'h00_0000, pb_drv}, 32'h0000_03FF);
		for (int k = 0; k < 8; k++) begin
			rc(ix[k], rv[k]);
			wr(ix[k], 8'hFF);
		end
		for (int k = 0; k < 8; k++) begin
			rc(ix[k], fv[k]);
		end
		// Port B output and input levels
		wr(8'hA1, 8'h0A);
		settle;
		chk({22'h00_0000, pb_drv}, 32'h0000_0140);
		rc(8'hA2, 8'h0A);
		// Write with byte lane 0 off is dropped
		sel <= 4'h0;
		wr(8'hA1, 8'h1F);
		sel <= 4'h1;
		rc(8'hA1, 8'h0A);
		wr(8'hA0, 8'h00);
		rc(8'hA2, 8'h15);
		// Port A drive types: open drain only pulls low
		wr(8'hB3, 8'h00);
		wr(8'hB1, 8'h00);
		settle;
		chk({16'h0000, pa_drv}, 32'h0000_0000);
		wr(8'hB1, 8'h0F);
		settle;
		chk({16'h0000, pa_drv}, 32'h0000_0F0F);
		wr(8'hB3, 8'hFF);
		settle;
		chk({16'h0000, pa_drv}, 32'h0000_0F00);
		rc(8'hB2, 8'h0F);
		wr(8'hB0, 8'h00);
		settle;
		chk({16'h0000, pa_drv}, 32'h0000_0FFF);
		// Falling edges on bits 1 and 3, wake enabled on all
		pa_ext <= 8'hA5;
		settle;
		rc(8'hB6, 8'h0A);
		chk({31'h0, wake}, 32'h0000_0001);
		rc(8'hB2, 8'hA5);
		wr(8'hB6, 8'h00);
		rc(8'hB6, 8'h0A);
		wr(8'hB6, 8'h02);
		rc(8'hB6, 8'h08);
		wr(8'hB4, 8'h00);
		settle;
		chk({31'h0, wake}, 32'h0000_0000);
		// Rising select: falls ignored, rises caught
		wr(8'hB5, 8'h00);
		pa_ext <= 8'hA0;
		settle;
		rc(8'hB6, 8'h08);
		pa_ext <= 8'hAF;
		settle;
		rc(8'hB6, 8'h0F);
		wr(8'hB4, 8'h08);
		settle;
		chk({31'h0, wake}, 32'h0000_0001);
		// Wake through bit 0, then clear bit 0
		wr(8'hB4, 8'h01);
		settle;
		chk({31'h0, wake}, 32'h0000_0001);
		wr(8'hB6, 8'h01);
		rc(8'hB6, 8'h0E);
		settle;
		chk({31'h0, wake}, 32'h0000_0000);
		report_and_stop;
	end
endmodule : gpe_top_tb
